// file: hdl/bmsi_pkg.sv
// Purpose: Shared constants and types for the module select and interrupt id block.
// Assumes: 125 MHz system clock, eight-bit card/device address.
// Notes: Timing counts derive from times in nanoseconds.
package bmsi_pkg;

    // Address field layout: card selector high nibble, device selector low nibble.
    localparam int ADDR_W = 8;
    localparam int CARD_LSB = 4;
    localparam int SEL_W = 4;
    localparam int NUM_SEL = 16;
    localparam int DATA_W = 8;

    // Default card number and the device selector of the id device.
    localparam logic [3:0] CARD_NUM_RST = 4'h0;
    localparam logic [3:0] ID_DEV_SEL = 4'hF;

    // Most data devices that dedicated select lines can serve.
    localparam int DIRECT_MAX = 8;

    // Id byte layout: flag bit marks a pending request, low bits carry the number.
    localparam int ID_FLAG_BIT = 7;
    localparam int ID_NUM_W = 3;

    // Width of a derived strobe pulse in fast-bus mode.
    localparam int CLK_PERIOD_PS = 8000;
    localparam int STROBE_NS = 200;
    localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STB_CNT_W = 8;

    // Buffer entry: device selector plus data byte.
    localparam int WBUF_W = SEL_W + DATA_W;
    localparam int WBUF_DEPTH = 2;

    // Synchronised pin vector width and bit positions.
    localparam int PIN_W = 29;
    localparam int PIN_IRQ_LSB = 0;
    localparam int PIN_ACK_BIT = 8;
    localparam int PIN_OBF_BIT = 9;
    localparam int PIN_WR_BIT = 10;
    localparam int PIN_RD_BIT = 11;
    localparam int PIN_BANK_BIT = 12;
    localparam int PIN_ADDR_LSB = 13;
    localparam int PIN_DATA_LSB = 21;

    // Fast-bus strobe sequencer states.
    typedef enum logic [1:0] {ST_IDLE, ST_RD_PULSE, ST_RD_LOAD, ST_WR_PULSE} bmsi_fsm_e;

endpackage

// file: hdl/bmsi_stream_if.sv
// Purpose: Valid/ready carrier for write words between strobe logic and buffer.
// Assumes: Single clock domain.
// Notes: Source drives valid and data, sink drives ready.
`timescale 1ns/1ps
interface bmsi_stream_if #(parameter int W = 12);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: hdl/bmsi_wbuf.sv
// Purpose: Small FIFO holding write words so a stall downstream loses no fast-bus write.
// Assumes: Downstream drains with valid/ready in the same clock domain.
// Notes: Depth and width are parameters; output valid and full are flops.
`timescale 1ns/1ps
module bmsi_wbuf #(
    parameter int W = 12,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic nrst,
    bmsi_stream_if.snk in_s,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import bmsi_pkg::*;

    localparam int PW = $clog2(DEPTH);

    // A power of two keeps pointer wrap free of extra compare logic.
    if (DEPTH < 2 || (1 << PW) != DEPTH)
    begin : g_bad_depth
        $error("bmsi_wbuf: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;
    logic full_q;
    logic valid_q;

    wire push = in_s.valid && !full_q;
    wire pop = out_valid && out_ready;
    wire [PW:0] cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);

    assign in_s.ready = !full_q;
    assign out_valid = valid_q;
    assign out_data = mem_q[rp_q];

    ////////////////////////////////////////////////////////////////////
    // Storage is not reset; only pointers and flags carry meaning.
    always_ff @(posedge clock)
    begin
        if (push)
            mem_q[wp_q] <= in_s.data;
    end

    // Pointers and honest full/valid flags, so the valid output is a flop.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            valid_q <= 1'b0;
        end
        else
        begin
            wp_q <= wp_q + PW'(push);
            rp_q <= rp_q + PW'(pop);
            cnt_q <= cnt_d;
            full_q <= (cnt_d == (PW+1)'(DEPTH));
            valid_q <= (cnt_d != '0);
        end
    end
endmodule

// file: hdl/bmsi_top.sv
// Purpose: Expansion module select decode, strobe generation and interrupt id device.
// Assumes: Host address and strobes are asynchronous pins; devices share this clock.
// Notes: The id device is the only data path driver inside this block.
//
// What this block does
// - Eight-bit address: card nibble, device nibble.
// - Direct select lines serve at most eight devices.
// - Read-only id device returns interrupting device number.
// - Id built from priority encoder, tri-state drive.
// - Transfers need select plus active-low strobe.
// - Fast-bus derives strobes from port handshakes.
// - Fast read returns previous byte; two reads.
// - Decoded select: match card first, then one device.
// - Bank expand low disables all decoding.
// - Interrupt lines asserted asynchronously, any time.
`timescale 1ns/1ps
module bmsi_top #(
    parameter logic [3:0] CARD_NUM = bmsi_pkg::CARD_NUM_RST,
    parameter bit DIRECT_SELECT = 1'b0,
    parameter int NUM_DEVS = 8,
    parameter logic [7:0] LVL7_MASK = 8'h00
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic fast_mode,
    input wire logic [bmsi_pkg::ADDR_W-1:0] card_dev_addr,
    input wire logic bank_expand,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic host_out_full_n,
    input wire logic host_in_ack_n,
    input wire logic [bmsi_pkg::DATA_W-1:0] data_in,
    output logic [bmsi_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic host_in_stb_n,
    output logic host_out_ack_n,
    input wire logic [7:0] dev_irq,
    output logic external_interrupt_request,
    output logic level7_interrupt_request,
    output logic [bmsi_pkg::NUM_SEL-1:0] dev_sel,
    output logic dev_rd_n,
    output logic dev_wr_n,
    output logic wq_valid,
    input wire logic wq_ready,
    output logic [bmsi_pkg::SEL_W-1:0] wq_dev,
    output logic [bmsi_pkg::DATA_W-1:0] wq_data
);
    import bmsi_pkg::*;

    // Elaboration checks: a device count the decode cannot serve stops the build.
    if (NUM_DEVS < 1 || NUM_DEVS > NUM_SEL)
    begin : g_bad_devs
        $error("bmsi_top: NUM_DEVS out of range");
    end
    if (DIRECT_SELECT && NUM_DEVS > DIRECT_MAX)
    begin : g_bad_direct
        $error("bmsi_top: direct select serves at most eight devices");
    end

    // Lowest request number wins; returns flag plus number.
    function automatic logic [DATA_W-1:0] prio_id(input logic [7:0] req);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 7; i >= 0; i--)
        begin
            if (req[i])
                r = {1'b1, 4'h0, i[ID_NUM_W-1:0]};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchroniser: three flops, a change counts when stages two and three agree.
    wire [PIN_W-1:0] pins_raw = {data_in, card_dev_addr, bank_expand, rd_n, wr_n,
                                 host_out_full_n, host_in_ack_n, dev_irq};
    logic [PIN_W-1:0] s1_q;
    logic [PIN_W-1:0] s2_q;
    logic [PIN_W-1:0] s3_q;
    logic [PIN_W-1:0] pin_q;
    wire [PIN_W-1:0] agree = ~(s2_q ^ s3_q);
    wire [PIN_W-1:0] pin_d = (s2_q & agree) | (pin_q & ~agree);
    localparam logic [PIN_W-1:0] PIN_RST = {8'h00, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00};

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= PIN_RST;
            s2_q <= PIN_RST;
            s3_q <= PIN_RST;
            pin_q <= PIN_RST;
        end
        else
        begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
        end
    end

    // Named views of the filtered pins.
    wire [7:0] irq_f = pin_q[PIN_IRQ_LSB +: 8];
    wire ack_n_f = pin_q[PIN_ACK_BIT];
    wire obf_n_f = pin_q[PIN_OBF_BIT];
    wire wr_n_f = pin_q[PIN_WR_BIT];
    wire rd_n_f = pin_q[PIN_RD_BIT];
    wire bank_f = pin_q[PIN_BANK_BIT];
    wire [ADDR_W-1:0] addr_f = pin_q[PIN_ADDR_LSB +: ADDR_W];
    wire [DATA_W-1:0] bus_f = pin_q[PIN_DATA_LSB +: DATA_W];

    ////////////////////////////////////////////////////////////////////
    // Address decode. The host keeps the address latched, so no capture is needed.
    wire [SEL_W-1:0] card_f = addr_f[CARD_LSB +: SEL_W];
    wire [SEL_W-1:0] devsel_f = addr_f[SEL_W-1:0];
    wire card_hit = bank_f && (card_f == CARD_NUM);
    wire one_hot8 = (addr_f != '0) && ((addr_f & (addr_f - 8'h01)) == '0);
    wire direct_ok = bank_f && one_hot8 && (addr_f < (9'(1) << NUM_DEVS));
    wire dec_ok = card_hit && ((int'(devsel_f) < NUM_DEVS) || devsel_f == ID_DEV_SEL);
    wire [NUM_SEL-1:0] sel_dec = dec_ok ? (NUM_SEL'(1) << devsel_f) : '0;
    wire [NUM_SEL-1:0] sel_dir = direct_ok ? {8'h00, addr_f} : '0;
    wire [NUM_SEL-1:0] sel_now = DIRECT_SELECT ? sel_dir : sel_dec;
    wire id_hit = !DIRECT_SELECT && dec_ok && (devsel_f == ID_DEV_SEL);
    wire any_sel = |sel_now;
    wire [SEL_W-1:0] sel_num = DIRECT_SELECT ? SEL_W'($clog2(addr_f)) : devsel_f;

    // Interrupt id byte from the priority encoder.
    wire [DATA_W-1:0] id_byte = prio_id(irq_f);

    ////////////////////////////////////////////////////////////////////
    // Fast-bus sequencer and strobe timing.
    bmsi_fsm_e st_q;
    bmsi_fsm_e st_d;
    logic [STB_CNT_W-1:0] cnt_q;
    logic ack_n_d1_q;
    logic wr_pend_q;
    logic [WBUF_W-1:0] wr_word_q;
    logic wr_n_d1_q;

    wire ack_fall = ack_n_d1_q && !ack_n_f;
    wire cnt_done = (cnt_q == STB_CNT_W'(STROBE_CYC - 1));
    wire wr_rise = !wr_n_d1_q && wr_n_f;

    // Next state; a pending write blocks new fast writes so the host is held off.
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE:
            begin
                if (fast_mode && ack_fall && any_sel)
                    st_d = ST_RD_PULSE;
                else if (fast_mode && !obf_n_f && !wr_pend_q && any_sel)
                    st_d = ST_WR_PULSE;
            end
            ST_RD_PULSE:
            begin
                if (cnt_done)
                    st_d = ST_RD_LOAD;
            end
            ST_RD_LOAD:
                st_d = ST_IDLE;
            ST_WR_PULSE:
            begin
                if (cnt_done)
                    st_d = ST_IDLE;
            end
        endcase
    end

    // Effective strobes: handshake-derived in fast mode, host pins otherwise.
    wire fast_rd = (st_q == ST_RD_PULSE);
    wire fast_wr = (st_q == ST_WR_PULSE);
    wire rd_act = fast_mode ? fast_rd : !rd_n_f;
    wire wr_act = fast_mode ? fast_wr : !wr_n_f;
    wire wr_end = fast_mode ? (fast_wr && cnt_done) : (wr_rise && any_sel);

    // Write word handed to the buffer; held while the buffer is full.
    bmsi_stream_if #(.W(WBUF_W)) wsrc ();
    assign wsrc.valid = wr_pend_q;
    assign wsrc.data = wr_word_q;

    ////////////////////////////////////////////////////////////////////
    // Sequencer registers.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            ack_n_d1_q <= 1'b1;
            wr_n_d1_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= (st_d != st_q || st_q == ST_IDLE) ? '0 : cnt_q + STB_CNT_W'(1);
            ack_n_d1_q <= ack_n_f;
            wr_n_d1_q <= wr_n_f;
        end
    end

    // Write capture; the data is taken at the end of the strobe.
    // A new word wins over the push that frees the slot in the same cycle.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_pend_q <= 1'b0;
            wr_word_q <= '0;
        end
        else if (wr_end && (!wr_pend_q || wsrc.ready))
        begin
            wr_pend_q <= 1'b1;
            wr_word_q <= {sel_num, bus_f};
        end
        else if (wsrc.ready)
            wr_pend_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs toward devices, host port and data path.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            dev_sel <= '0;
            dev_rd_n <= 1'b1;
            dev_wr_n <= 1'b1;
            data_out <= '0;
            data_oe <= 1'b0;
            host_in_stb_n <= 1'b1;
            host_out_ack_n <= 1'b1;
            external_interrupt_request <= 1'b0;
            level7_interrupt_request <= 1'b0;
        end
        else
        begin
            dev_sel <= sel_now;
            dev_rd_n <= !(rd_act && any_sel);
            dev_wr_n <= !(wr_act && any_sel);
            data_out <= (id_hit && rd_act) ? id_byte : '0;
            data_oe <= id_hit && rd_act;
            host_in_stb_n <= !(st_q == ST_RD_LOAD);
            host_out_ack_n <= !fast_wr;
            external_interrupt_request <= |(irq_f & ~LVL7_MASK);
            level7_interrupt_request <= |(irq_f & LVL7_MASK);
        end
    end

    // Two-entry buffer between capture and the device write port.
    bmsi_wbuf #(.W(WBUF_W), .DEPTH(WBUF_DEPTH)) u_wbuf (
        .clock(clock),
        .nrst(nrst),
        .in_s(wsrc),
        .out_valid(wq_valid),
        .out_ready(wq_ready),
        .out_data({wq_dev, wq_data})
    );
endmodule

// file: sim/bmsi_top_assertions.sv
// Purpose: Concurrent checks on the ports of the select and id block.
// Assumes: One clock; nrst is asynchronous and active low.
// Notes: Eight-cycle settle windows cover the pin filter latency.
`timescale 1ns/1ps
module bmsi_top_chk #(
    parameter logic [3:0] CARD_NUM = bmsi_pkg::CARD_NUM_RST,
    parameter logic [7:0] LVL7_MASK = 8'h00
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic fast_mode,
    input wire logic [bmsi_pkg::ADDR_W-1:0] card_dev_addr,
    input wire logic bank_expand,
    input wire logic [bmsi_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic host_in_stb_n,
    input wire logic host_out_ack_n,
    input wire logic [7:0] dev_irq,
    input wire logic external_interrupt_request,
    input wire logic level7_interrupt_request,
    input wire logic [bmsi_pkg::NUM_SEL-1:0] dev_sel,
    input wire logic dev_rd_n,
    input wire logic dev_wr_n,
    input wire logic wq_valid,
    input wire logic wq_ready,
    input wire logic [bmsi_pkg::SEL_W-1:0] wq_dev,
    input wire logic [bmsi_pkg::DATA_W-1:0] wq_data
);
    import bmsi_pkg::*;
    logic [7:0] rd_cnt_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // Lowest requesting device wins, flag in the top bit.
    function automatic logic [7:0] id_of(input logic [7:0] r);
        id_of = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            if (r[i])
            begin
                id_of = 8'h80 | {5'h00, i[2:0]};
            end
        end
    endfunction

    // Counts low cycles of the device read strobe so its width can be checked.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_cnt_q <= 8'h00;
        end
        else
        begin
            rd_cnt_q <= dev_rd_n ? 8'h00 : rd_cnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////
    AST_ONE_SEL: assert property ($onehot0(dev_sel))
        else $error("more than one device selected");
    AST_BANK_OFF: assert property (!bank_expand [*8] |-> dev_sel == 16'h0000)
        else $error("select while bank disabled");
    AST_CARD_MISS: assert property ((card_dev_addr[7:4] != CARD_NUM) [*8]
        |-> dev_sel == 16'h0000) else $error("select with other card number");
    AST_STB_SEL: assert property (!(dev_rd_n && dev_wr_n) |-> dev_sel != 16'h0000)
        else $error("strobe without a select");
    AST_OE_ID: assert property (data_oe |-> dev_sel[ID_DEV_SEL] && !dev_rd_n)
        else $error("id driver on outside an id read");
    AST_OE_OFF: assert property (!data_oe |-> data_out == 8'h00)
        else $error("id byte present while not driving");
    AST_ID_VAL: assert property ($stable(dev_irq) [*8] ##0 data_oe
        |-> data_out == id_of(dev_irq)) else $error("id byte wrong");
    AST_IRQ_LINES: assert property ($stable(dev_irq) [*8]
        |-> external_interrupt_request == |(dev_irq & ~LVL7_MASK)
        && level7_interrupt_request == |(dev_irq & LVL7_MASK))
        else $error("request lines wrong");
    AST_FAST_RD_LEN: assert property (fast_mode && $rose(dev_rd_n)
        |-> rd_cnt_q == STROBE_CYC) else $error("read strobe width wrong");
    AST_IN_STB: assert property (fast_mode && $rose(dev_rd_n)
        |-> !host_in_stb_n ##1 host_in_stb_n) else $error("input strobe missing");
    AST_WR_PAIR: assert property (!host_out_ack_n |-> !dev_wr_n)
        else $error("ack without write strobe");
    AST_WQ_HOLD: assert property (wq_valid && !wq_ready |=> wq_valid
        && $stable({wq_dev, wq_data})) else $error("head word changed in stall");

    // Main scenarios reached.
    COV_FAST_RD: cover property (fast_mode && $rose(dev_rd_n));
    COV_FAST_WR: cover property ($fell(host_out_ack_n));
    COV_ID_RD: cover property (data_oe && data_out[7]);
    COV_STALL: cover property (wq_valid && !wq_ready [*4]);
endmodule

bind bmsi_top bmsi_top_chk #(.CARD_NUM(CARD_NUM), .LVL7_MASK(LVL7_MASK)) u_chk (
    .clock, .nrst, .fast_mode, .card_dev_addr, .bank_expand, .data_out, .data_oe,
    .host_in_stb_n, .host_out_ack_n, .dev_irq, .external_interrupt_request,
    .level7_interrupt_request, .dev_sel, .dev_rd_n, .dev_wr_n, .wq_valid, .wq_ready,
    .wq_dev, .wq_data
);

// file: sim/bmsi_host_model.sv
// Purpose: Host parallel port model driving address, strobes and handshakes.
// Assumes: Pins change one nanosecond after a rising edge.
// Notes: Every transfer lasts well over 107 cycles.
`timescale 1ns/1ps
module bmsi_host_model (
    input wire logic clock,
    input wire logic [bmsi_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic host_in_stb_n,
    input wire logic host_out_ack_n,
    output logic [bmsi_pkg::ADDR_W-1:0] card_dev_addr,
    output logic bank_expand,
    output logic rd_n,
    output logic wr_n,
    output logic host_out_full_n,
    output logic host_in_ack_n,
    output logic [bmsi_pkg::DATA_W-1:0] data_in
);
    import bmsi_pkg::*;
    logic [7:0] drv_q = 8'h00;
    logic drv_en = 1'h0;
    logic [7:0] last_q = 8'h00;
    logic [7:0] seen_q = 8'h00;
    logic [7:0] in_buf = 8'h00;

    // Released path shows a changing pattern, never a held value.
    assign data_in = data_oe ? data_out : (drv_en ? drv_q : ~last_q);

    // Port latch keeps the last driven byte and loads it on the input strobe.
    always @(posedge clock)
    begin
        last_q <= data_in;
        seen_q <= data_oe ? data_in : seen_q;
        in_buf <= host_in_stb_n ? in_buf : seen_q;
    end

    initial
    begin
        card_dev_addr = 8'h00;
        {bank_expand, rd_n, wr_n, host_out_full_n, host_in_ack_n} = 5'h0f;
    end

    task automatic set_addr(input logic [7:0] a, input logic b);
        @(posedge clock);
        #1;
        card_dev_addr = a;
        bank_expand = b;
    endtask

    // Address first, then strobe, address held to the end.
    task automatic sw_xfer(input logic [7:0] a, input logic wr, input logic [7:0] d,
        output logic [7:0] q);
        set_addr(a, 1'h1);
        drv_q = d;
        drv_en = wr;
        repeat (8) @(posedge clock);
        #1;
        wr_n = !wr;
        rd_n = wr;
        repeat (12) @(posedge clock);
        #1;
        q = data_in;
        wr_n = 1'h1;
        rd_n = 1'h1;
        repeat (100) @(posedge clock);
        #1;
        drv_en = 1'h0;
    endtask

    // Taking the buffered byte starts the next device read.
    task automatic fast_read(input logic [7:0] a, output logic ok, output logic [7:0] q);
        set_addr(a, 1'h1);
        q = in_buf;
        ok = 1'h0;
        host_in_ack_n = 1'h0;
        repeat (8) @(posedge clock);
        #1;
        host_in_ack_n = 1'h1;
        repeat (110)
        begin
            @(posedge clock);
            #1;
            ok = ok | !host_in_stb_n;
        end
    endtask

    // Full stays low until acknowledged; a refused word is left waiting.
    task automatic fast_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
        set_addr(a, 1'h1);
        drv_q = d;
        drv_en = 1'h1;
        host_out_full_n = 1'h0;
        ok = 1'h0;
        repeat (150)
        begin
            @(posedge clock);
            #1;
            ok = ok | !host_out_ack_n;
            host_out_full_n = host_out_full_n | !host_out_ack_n;
        end
        drv_en = !ok;
    endtask
endmodule

// file: sim/bmsi_top_tb_top.sv
// Purpose: Self-checking bench for the select and id block.
// Assumes: Host model spaces transfers; ready is random unless stalled.
// Notes: Seed is fixed so every run repeats.
`timescale 1ns/1ps
module bmsi_top_tb_top;
    import bmsi_pkg::*;
    localparam logic [3:0] CARD = 4'h5;
    localparam logic [7:0] L7 = 8'hf0;
    logic clock = 1'h0;
    logic nrst = 1'h0;
    logic fast_mode = 1'h0;
    logic wq_ready = 1'h0;
    logic stall = 1'h0;
    logic [7:0] dev_irq = 8'h00;
    logic [7:0] card_dev_addr, data_in, data_out, a, d, q;
    logic bank_expand, rd_n, wr_n, host_out_full_n, host_in_ack_n, ok;
    logic data_oe, host_in_stb_n, host_out_ack_n, dev_rd_n, dev_wr_n, wq_valid;
    logic external_interrupt_request, level7_interrupt_request;
    logic [15:0] dev_sel;
    logic [3:0] wq_dev;
    logic [7:0] wq_data;
    logic [11:0] exp_q[$];
    int errors = 0;
    int tests_run = 0;
    int seed = 40895;

    bmsi_top #(.CARD_NUM(CARD), .LVL7_MASK(L7)) DUT (.clock, .nrst, .fast_mode,
        .card_dev_addr, .bank_expand, .rd_n, .wr_n, .host_out_full_n, .host_in_ack_n,
        .data_in, .data_out, .data_oe, .host_in_stb_n, .host_out_ack_n, .dev_irq,
        .external_interrupt_request, .level7_interrupt_request, .dev_sel, .dev_rd_n,
        .dev_wr_n, .wq_valid, .wq_ready, .wq_dev, .wq_data);
    bmsi_host_model hm (.clock, .data_out, .data_oe, .host_in_stb_n, .host_out_ack_n,
        .card_dev_addr, .bank_expand, .rd_n, .wr_n, .host_out_full_n, .host_in_ack_n,
        .data_in);

    ////////////////////////////////////////
    function automatic logic [15:0] exp_sel(input logic [7:0] x, input logic b);
        exp_sel = 16'h0000;
        if (b && x[7:4] == CARD && (x[3:0] < 4'h8 || x[3:0] == ID_DEV_SEL))
        begin
            exp_sel[x[3:0]] = 1'h1;
        end
    endfunction

    function automatic logic [7:0] exp_id(input logic [7:0] r);
        exp_id = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            if (r[i])
            begin
                exp_id = 8'h80 | {5'h00, i[2:0]};
            end
        end
    endfunction

    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Clock and a receiver that stalls at random or on demand.
    always #4 clock = ~clock;
    always @(posedge clock)
    begin
        #1;
        wq_ready = !stall && ($random(seed) % 3 != 0);
    end

    // Words are judged where the handshake completes.
    always @(negedge clock)
    begin
        if (nrst && wq_valid === 1'h1 && wq_ready)
        begin
            check("wq word", exp_q.pop_front(), {wq_dev, wq_data});
        end
    end

    initial
    begin
        #100_000;
        errors++;
        $display("wrong value watchdog expected done seen hang");
        finish_test();
    end

    initial
    begin
        repeat (5) @(posedge clock);
        check("reset outs", 16'h000f, {data_oe, wq_valid, external_interrupt_request,
            level7_interrupt_request, dev_rd_n, dev_wr_n, host_in_stb_n, host_out_ack_n});
        check("reset sel", 16'h0000, dev_sel);
        #1;
        nrst = 1'h1;
        for (int i = 0; i < 24; i++)
        begin
            a = (i < 16) ? {CARD, i[3:0]} : 8'($random(seed));
            a[7:4] = (i < 16 || i[0]) ? CARD : a[7:4];
            hm.set_addr(a, i < 20);
            repeat (8) @(posedge clock);
            #1;
            check("dev_sel", exp_sel(a, i < 20), dev_sel);
        end
        for (int i = 0; i < 6; i++)
        begin
            a = {CARD, 1'h0, 3'($random(seed))};
            d = $random(seed);
            exp_q.push_back({a[3:0], d});
            hm.sw_xfer(a, 1'h1, d, q);
        end
        for (int i = 0; i < 9; i++)
        begin
            dev_irq = i[0] ? 8'($random(seed)) : 8'h80 >> i;
            hm.sw_xfer({CARD, ID_DEV_SEL}, 1'h0, 8'h00, q);
            check("id byte", exp_id(dev_irq), q);
            check("irq lines", {|(dev_irq & ~L7), |(dev_irq & L7)},
                {external_interrupt_request, level7_interrupt_request});
        end
        fast_mode = 1'h1;
        dev_irq = 8'h24;
        hm.fast_read({CARD, ID_DEV_SEL}, ok, q);
        check("in strobe", 16'h0001, ok);
        check("stale byte", 16'h0000, q);
        hm.fast_read({CARD, ID_DEV_SEL}, ok, q);
        check("fresh byte", exp_id(8'h24), q);
        check("fresh strobe", 16'h0001, ok);
        stall = 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            a = {CARD, 1'h0, 3'($random(seed))};
            d = $random(seed);
            exp_q.push_back({a[3:0], d});
            hm.fast_write(a, d, ok);
            check("wr accept", i < 3, ok);
        end
        stall = 1'h0;
        hm.fast_write(a, d, ok);
        check("wr retry", 16'h0001, ok);
        repeat (60) @(posedge clock);
        #1;
        check("wq left", 16'h0000, {exp_q.size() != 0, wq_valid});
        finish_test();
    end
endmodule
